// ===== core/cci_error_state.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Error state decode from the two error counters
// ----------------------------------------------------------------------
module cci_error_state (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic [8:0]           tx_err_count,
    input  wire logic [8:0]           rx_err_count,
    output cci_pkg::cci_estate_t      estate_q,
    output logic                      change_q
);

    cci_pkg::cci_estate_t estate_d; // Decoded state this cycle.

    // Warning, passive and bus-off limits from the counter values.
    assign estate_d.tx_warn    = tx_err_count >= cci_pkg::LIM_WARN;
    assign estate_d.rx_warn    = rx_err_count >= cci_pkg::LIM_WARN;
    assign estate_d.tx_passive = tx_err_count >  cci_pkg::LIM_PASSIVE;
    assign estate_d.rx_passive = rx_err_count >  cci_pkg::LIM_PASSIVE;
    assign estate_d.busoff     = tx_err_count >  cci_pkg::LIM_BUSOFF;
    assign estate_d.any_warn   = estate_d.tx_warn | estate_d.rx_warn;

    // Register the state and pulse when any bit of it moves.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            estate_q <= cci_pkg::RST_ESTATE;
            change_q <= 1'b0;
        end else begin
            estate_q <= estate_d;
            change_q <= estate_d != estate_q;
        end
    end

    // Bus-off must follow a counter beyond 255 by one cycle.
    a_busoff_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (tx_err_count > 9'h0FF) |=> estate_q.busoff)
        else $error("Bus-off not shown for a counter beyond the limit.");

    // A change of state is pulsed on the same edge that registers it.
    a_change_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($past(estate_d) != $past(estate_q)) |-> change_q)
        else $error("Error state change was not pulsed.");

endmodule : cci_error_state

// ===== core/cci_interrupt_unit.sv
// Function
// - Eight sources, each with enable and flag.
// - Pending enabled source holds interrupt output low.
// - Flag cannot clear while its condition persists.
// - Host-set flag interrupts like a hardware event.
// - Output low until all cleared; code shows top.
// - Lower code is higher priority, updates immediately.
// - Code considers only enabled sources.
// - Code values: none, error, wake, tx, rx.
// - Transmit buffer empty sets its flag.
// - Received message sets receive flag after frame.
// - Any message error sets message error flag.
// - Bus activity in sleep sets wakeup, exits; here only with the wakeup enable set.
// - Overflow or error state change sets error flag.
// - Overflow bit set on occupied buffer, host clears.
// - Warning when an error counter reaches 96.
// - Passive signalled when counter exceeds 127.
// - Bus-off when transmit counter exceeds 255.
// - Pending while any associated flag remains set.
// - Enable bit order, all read/write, reset zero.
// - Flag register at 2Ch, same bit order.
// - Buffer overflow bit stays until host resets.
`timescale 1ns/1ps

module cci_interrupt_unit #(
    parameter int NUM_SRC = 8 // Number of interrupt sources.
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire cci_pkg::cci_req_t reg_req,
    input  wire cci_pkg::cci_evt_t evt,
    input  wire logic              asleep,
    input  wire logic [8:0]        tx_err_count,
    input  wire logic [8:0]        rx_err_count,
    output logic [7:0]             reg_rdata_q,
    output logic                   reg_rvalid_q,
    output logic                   int_n_q,
    output logic [2:0]             pending_source_code_q,
    output logic                   wake_req_q,
    output cci_pkg::cci_estate_t   error_state_q
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Highest priority enabled pending source; message error has no code.
    function automatic logic [2:0] cci_prio_code(input logic [NUM_SRC-1:0] act);
        logic [2:0] code;
        code = cci_pkg::CODE_NONE;
        if (act[cci_pkg::BIT_RX1]) code = cci_pkg::CODE_RX1;
        if (act[cci_pkg::BIT_RX0]) code = cci_pkg::CODE_RX0;
        if (act[cci_pkg::BIT_TX2]) code = cci_pkg::CODE_TX2;
        if (act[cci_pkg::BIT_TX1]) code = cci_pkg::CODE_TX1;
        if (act[cci_pkg::BIT_TX0]) code = cci_pkg::CODE_TX0;
        if (act[cci_pkg::BIT_WAKE]) code = cci_pkg::CODE_WAKE;
        if (act[cci_pkg::BIT_ERR]) code = cci_pkg::CODE_ERR;
        return code;
    endfunction : cci_prio_code

    // Apply a masked write to a stored value.
    function automatic logic [7:0] cci_merge(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] msk);
        return (old & ~msk) | (wd & msk);
    endfunction : cci_merge

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0]   enables_q;   // Interrupt source enables.
    logic [NUM_SRC-1:0]   enables_d;   // Next enable value, after any host write.
    logic [NUM_SRC-1:0]   flags_q;     // Interrupt source flags.
    logic [NUM_SRC-1:0]   flags_d;     // Next flag value.
    logic [1:0]           ovr_q;       // Receive buffer overflow bits.
    logic [1:0]           ovr_d;       // Next overflow value.
    cci_pkg::cci_estate_t estate;      // Decoded error state.
    logic                 estate_chg;  // Error state moved last cycle.

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    wire wr_en   = reg_req.wr && (reg_req.addr == cci_pkg::ADDR_ENABLES);
    wire wr_flg  = reg_req.wr && (reg_req.addr == cci_pkg::ADDR_FLAGS);
    wire wr_ef   = reg_req.wr && (reg_req.addr == cci_pkg::ADDR_ERRFLAGS);
    wire [1:0] ef_wd  = reg_req.wdata[cci_pkg::EF_OVR_LSB +: 2];
    wire [1:0] ef_msk = reg_req.mask[cci_pkg::EF_OVR_LSB +: 2];

    // Enables as they stand after this edge. The outputs are computed from this
    // value so that an enable write and the interrupt pin move on the same edge;
    // a one-edge lag would leave the pin high with an enabled flag pending.
    assign enables_d = wr_en ? cci_merge(enables_q, reg_req.wdata, reg_req.mask)
                             : enables_q;

    // ------------------------------------------------------------------
    // Hardware events
    // ------------------------------------------------------------------
    // A message for a full receive buffer is an overflow, not a load.
    wire [1:0] rx_load = evt.rx_msg_valid & ~flags_q[cci_pkg::BIT_RX1:cci_pkg::BIT_RX0];
    wire [1:0] rx_ovf  = evt.rx_msg_valid & flags_q[cci_pkg::BIT_RX1:cci_pkg::BIT_RX0];
    // Wakeup only counts while asleep with its enable set.
    wire wake_evt = asleep && evt.bus_activity && enables_q[cci_pkg::BIT_WAKE];
    wire err_evt  = (|rx_ovf) || estate_chg;

    // Set vector in register bit order.
    wire [NUM_SRC-1:0] set_evt = {evt.msg_error, wake_evt, err_evt,
                                  evt.tx_empty, rx_load};

    // Conditions that still prevail keep their flag against a host clear.
    wire [NUM_SRC-1:0] hold = set_evt |
                              ({{(NUM_SRC-1){1'b0}}, |ovr_q} << cci_pkg::BIT_ERR);

    // Host write result, then held bits, then hardware sets on top.
    wire [7:0] flg_wr = wr_flg ? cci_merge(flags_q, reg_req.wdata, reg_req.mask)
                               : flags_q;
    assign flags_d = flg_wr | (flags_q & hold) | set_evt;

    // Overflow bits: host may clear, a new overflow wins over the clear.
    wire [1:0] ovr_wr = wr_ef ? ((ovr_q & ~ef_msk) | (ef_wd & ef_msk)) : ovr_q;
    assign ovr_d = ovr_wr | rx_ovf;

    // Enabled pending sources drive both outputs.
    // Both the next flags and the next enables feed the registered outputs.
    wire [NUM_SRC-1:0] active_d = flags_d & enables_d;
    wire [NUM_SRC-1:0] active_q = flags_q & enables_q;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    wire [7:0] status_rd = 8'(pending_source_code_q) << cci_pkg::STAT_CODE_LSB;
    wire [7:0] ef_rd     = {ovr_q, estate};
    wire [7:0] rd_mux    = (reg_req.addr == cci_pkg::ADDR_ENABLES)  ? enables_q :
                           (reg_req.addr == cci_pkg::ADDR_FLAGS)    ? flags_q   :
                           (reg_req.addr == cci_pkg::ADDR_ERRFLAGS) ? ef_rd     :
                           (reg_req.addr == cci_pkg::ADDR_STATUS)   ? status_rd :
                           8'h00;

    // ------------------------------------------------------------------
    // Error state decode
    // ------------------------------------------------------------------
    cci_error_state u_estate (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .tx_err_count (tx_err_count),
        .rx_err_count (rx_err_count),
        .estate_q     (estate),
        .change_q     (estate_chg)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // Enable register, plain read/write with bit mask.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enables_q <= cci_pkg::RST_ENABLES;
        end else begin
            // Unchanged unless the host writes the enable address.
            enables_q <= enables_d;
        end
    end

    // Flags and overflow bits.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= cci_pkg::RST_FLAGS;
            ovr_q   <= cci_pkg::RST_OVR;
        end else begin
            flags_q <= flags_d;
            ovr_q   <= ovr_d;
        end
    end

    // Interrupt output and pending code, both tracking the next flags and enables.
    // They therefore always match the flag and enable registers after each edge.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_n_q               <= 1'b1;
            pending_source_code_q <= cci_pkg::CODE_NONE;
        end else begin
            int_n_q               <= ~(|active_d);
            pending_source_code_q <= cci_prio_code(active_d);
        end
    end

    // Read answer, wakeup request and error state copy.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q   <= 8'h00;
            reg_rvalid_q  <= 1'b0;
            wake_req_q    <= 1'b0;
            error_state_q <= cci_pkg::RST_ESTATE;
        end else begin
            reg_rdata_q   <= reg_req.rd ? rd_mux : reg_rdata_q;
            reg_rvalid_q  <= reg_req.rd;
            wake_req_q    <= wake_evt;
            error_state_q <= estate;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    a_int_low_pending: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (|(flags_q & enables_q)) |-> !int_n_q)
        else $error("Interrupt output high with an enabled flag pending.");

    a_int_high_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(|(flags_q & enables_q)) |-> int_n_q)
        else $error("Interrupt output low with nothing pending.");

    a_code_tracks: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pending_source_code_q == cci_prio_code(active_q))
        else $error("Pending code does not match the enabled flags.");

    a_code_err_top: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (flags_q[5] && enables_q[5]) |-> (pending_source_code_q == 3'h1))
        else $error("Error source not reported as code one.");

    a_set_wins_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (|set_evt) |=> ((flags_q & $past(set_evt)) == $past(set_evt)))
        else $error("A hardware set was lost.");

    a_rx_overflow_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (evt.rx_msg_valid[1] && flags_q[1]) |=> (ovr_q[1] && flags_q[5]))
        else $error("Overflow on a full buffer not recorded.");

    a_wake_in_sleep: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wake_req_q |-> ($past(asleep) && $past(evt.bus_activity) && flags_q[6]))
        else $error("Wakeup request without bus activity in sleep.");

    a_host_set_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_flg && |(reg_req.wdata & reg_req.mask & enables_q)) |=> !int_n_q)
        else $error("Host-set enabled flag did not interrupt.");

    a_err_flag_held: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (|ovr_q && flags_q[5]) |=> flags_q[5])
        else $error("Error flag cleared while overflow still stands.");

endmodule : cci_interrupt_unit

// ===== core/cci_pkg.sv
package cci_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the device register port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS   = 8'h0E; // Controller status register.
    localparam logic [7:0] ADDR_ENABLES  = 8'h2B; // Interrupt source enables.
    localparam logic [7:0] ADDR_FLAGS    = 8'h2C; // Interrupt source flags.
    localparam logic [7:0] ADDR_ERRFLAGS = 8'h2D; // Error condition flags.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ENABLES = 8'h00; // All sources disabled.
    localparam logic [7:0] RST_FLAGS   = 8'h00; // No source pending.
    localparam logic [1:0] RST_OVR     = 2'h0;  // No receive overflow.
    localparam logic [5:0] RST_ESTATE  = 6'h00; // Error-active, no warning.

    // ------------------------------------------------------------------
    // Bit positions shared by the enable and flag registers
    // ------------------------------------------------------------------
    localparam int BIT_RX0  = 0; // Receive buffer 0 full.
    localparam int BIT_RX1  = 1; // Receive buffer 1 full.
    localparam int BIT_TX0  = 2; // Transmit buffer 0 empty.
    localparam int BIT_TX1  = 3; // Transmit buffer 1 empty.
    localparam int BIT_TX2  = 4; // Transmit buffer 2 empty.
    localparam int BIT_ERR  = 5; // Error state change or overflow.
    localparam int BIT_WAKE = 6; // Bus activity wakeup.
    localparam int BIT_MERR = 7; // Message error.

    // ------------------------------------------------------------------
    // Error condition and status register layout and limits
    // ------------------------------------------------------------------
    localparam int EF_OVR_LSB = 6; // Overflow bits sit at 7:6.
    localparam int STAT_CODE_LSB = 1; // Pending code sits at 3:1 of status.
    localparam logic [8:0] LIM_WARN    = 9'h060; // Warning at 96.
    localparam logic [8:0] LIM_PASSIVE = 9'h07F; // Passive above 127.
    localparam logic [8:0] LIM_BUSOFF  = 9'h0FF; // Bus-off above 255.

    // ------------------------------------------------------------------
    // Pending source codes, lower value means higher priority
    // ------------------------------------------------------------------
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_ERR  = 3'h1;
    localparam logic [2:0] CODE_WAKE = 3'h2;
    localparam logic [2:0] CODE_TX0  = 3'h3;
    localparam logic [2:0] CODE_TX1  = 3'h4;
    localparam logic [2:0] CODE_TX2  = 3'h5;
    localparam logic [2:0] CODE_RX0  = 3'h6;
    localparam logic [2:0] CODE_RX1  = 3'h7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // One register port access: write with bit mask, or read.
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle.
        logic       rd;    // Read strobe, one cycle.
        logic [7:0] addr;  // Register address.
        logic [7:0] wdata; // Write data.
        logic [7:0] mask;  // Bits to change; all ones for a plain write.
    } cci_req_t;

    // Hardware events from the protocol engine, each a one-cycle pulse.
    typedef struct packed {
        logic [2:0] tx_empty;     // Transmit buffer became empty.
        logic [1:0] rx_msg_valid; // Accepted message ready for a buffer.
        logic       msg_error;    // Error during a message.
        logic       bus_activity; // Activity seen on the CAN bus.
    } cci_evt_t;

    // Error state bits: bus-off, tx/rx passive, tx/rx warning, any warning.
    typedef struct packed {
        logic busoff;
        logic tx_passive;
        logic rx_passive;
        logic tx_warn;
        logic rx_warn;
        logic any_warn;
    } cci_estate_t;

endpackage : cci_pkg

// ===== dv/cci_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Host processor model on the register port
// ----------------------------------------------------------------------
module cci_host_model (
    input  wire logic         sys_clk,
    output cci_pkg::cci_req_t reg_req,
    input  wire logic [7:0]   reg_rdata_q,
    input  wire logic         reg_rvalid_q
);
    // The port is idle from time zero so nothing is taken during reset.
    initial begin
        reg_req = '0;
    end

    // Masked write; a mask of all ones makes it a plain write.
    task automatic put(input logic [7:0] addr, input logic [7:0] data, input logic [7:0] mask);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data, mask: mask};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
        #1;
    endtask : put

    // Read; the answer is awaited for a few edges at most.
    task automatic get(input logic [7:0] addr, output logic [7:0] data);
        int n;
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00, mask: 8'h00};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        n = 0;
        while (reg_rvalid_q !== 1'b1 && n < 3) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        data = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hXX;
    endtask : get
endmodule : cci_host_model

// ===== dv/cci_interrupt_unit_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Self-checking bench for the interrupt unit
// ----------------------------------------------------------------------
module cci_interrupt_unit_tb;
    logic                 sys_clk;     // Bench clock.
    logic                 sys_rst;     // Bench reset.
    cci_pkg::cci_req_t    reg_req;     // Host requests.
    cci_pkg::cci_evt_t    evt;         // Engine event pulses.
    logic                 asleep;      // Sleep mode level.
    logic [8:0]           tec;         // Transmit error counter.
    logic [8:0]           rec;         // Receive error counter.
    logic [7:0]           rdata;       // Read data.
    logic                 rvalid;      // Read data valid.
    logic                 int_n;       // Interrupt output.
    logic [2:0]           code;        // Pending source code.
    logic                 wake;        // Wakeup request.
    cci_pkg::cci_estate_t estate;      // Error state bits.
    logic [7:0]           rd_v;        // Last value read.
    int                   err_total;   // Mismatches.
    int                   n_tests;     // Comparisons.
    int                   cycles;      // Timeout counter.
    logic [2:0] code_of [8] = '{3'h6, 3'h7, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0};
    int         order   [8] = '{5, 6, 2, 3, 4, 0, 1, 7};
    logic [8:0] t_tec   [8] = '{9'd95, 9'd96, 9'd127, 9'd128, 9'd256, 9'd0, 9'd0, 9'd0};
    logic [8:0] t_rec   [8] = '{9'd0, 9'd0, 9'd0, 9'd0, 9'd0, 9'd96, 9'd128, 9'd0};
    logic [5:0] t_st    [8] = '{6'h00, 6'h05, 6'h05, 6'h15, 6'h35, 6'h03, 6'h0B, 6'h00};

    always #5 sys_clk = ~sys_clk;

    cci_host_model u_host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata_q(rdata),
                           .reg_rvalid_q(rvalid));

    cci_interrupt_unit #(.NUM_SRC(8)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .evt(evt),
        .asleep(asleep), .tx_err_count(tec), .rx_err_count(rec), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .int_n_q(int_n), .pending_source_code_q(code),
        .wake_req_q(wake), .error_state_q(estate));

    // Prints the verdict and ends the run.
    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Compares one value and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        u_host.get(addr, rd_v);
        chk(rd_v, exp);
    endtask : rchk

    // Compares the code and the interrupt output.
    task automatic outs(input logic [2:0] c, input logic n);
        chk({5'h00, code}, {5'h00, c});
        chk({7'h00, int_n}, {7'h00, n});
    endtask : outs

    // Sends the hardware event of one source for one cycle.
    task automatic pulse(input int b);
        cci_pkg::cci_evt_t e;
        e = '0;
        case (b)
            0, 1: e.rx_msg_valid[b] = 1'b1;
            2, 3, 4: e.tx_empty[b-2] = 1'b1;
            6: e.bus_activity = 1'b1;
            default: e.msg_error = 1'b1;
        endcase
        @(posedge sys_clk);
        evt <= e;
        @(posedge sys_clk);
        evt <= '0;
        #1;
    endtask : pulse

    // A hang counts as a mismatch.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // Main sequence.
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        evt = '0;
        asleep = 1'b0;
        tec = 9'h000;
        rec = 9'h000;
        err_total = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        outs(3'h0, 1'b1);
        rchk(cci_pkg::ADDR_ENABLES, 8'h00);
        rchk(cci_pkg::ADDR_FLAGS, 8'h00);
        rchk(cci_pkg::ADDR_STATUS, 8'h00);
        u_host.put(cci_pkg::ADDR_ENABLES, 8'hA5, 8'hFF);
        rchk(cci_pkg::ADDR_ENABLES, 8'hA5);
        u_host.put(8'h30, 8'hFF, 8'hFF);
        rchk(8'h30, 8'h00);
        // Each source but the error source (bit 5) alone: flag position, code, output, clear.
        u_host.put(cci_pkg::ADDR_ENABLES, 8'hFF, 8'hFF);
        @(posedge sys_clk) asleep <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i != 5) begin
                pulse(i);
                outs(code_of[i], 1'b0);
                if (i == 6) chk({7'h00, wake}, 8'h01);
                rchk(cci_pkg::ADDR_FLAGS, 8'h01 << i);
                u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h01 << i);
                outs(3'h0, 1'b1);
            end
        end
        @(posedge sys_clk) asleep <= 1'b0;
        pulse(6);
        chk({7'h00, wake}, 8'h00);
        rchk(cci_pkg::ADDR_FLAGS, 8'h00);
        // Host sets all flags, then clears them in priority order.
        u_host.put(cci_pkg::ADDR_FLAGS, 8'hFF, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            outs(code_of[order[i]], 1'b0);
            u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h01 << order[i]);
        end
        outs(3'h0, 1'b1);
        // Disabled sources are left out of the code.
        u_host.put(cci_pkg::ADDR_ENABLES, 8'h00, 8'hFF);
        u_host.put(cci_pkg::ADDR_FLAGS, 8'h18, 8'hFF);
        outs(3'h0, 1'b1);
        u_host.put(cci_pkg::ADDR_ENABLES, 8'h10, 8'hFF);
        @(posedge sys_clk);
        #1;
        outs(3'h5, 1'b0);
        u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'hFF);
        // A host clear in the same cycle as a set event loses.
        u_host.put(cci_pkg::ADDR_ENABLES, 8'h04, 8'hFF);
        fork
            u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h04);
            begin
                @(posedge sys_clk);
                evt.tx_empty[0] <= 1'b1;
                @(posedge sys_clk);
                evt <= '0;
            end
        join
        rchk(cci_pkg::ADDR_FLAGS, 8'h04);
        outs(3'h3, 1'b0);
        u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h04);
        // A second message for a full buffer overflows it.
        u_host.put(cci_pkg::ADDR_ENABLES, 8'h22, 8'hFF);
        pulse(1);
        pulse(1);
        rchk(cci_pkg::ADDR_ERRFLAGS, 8'h80);
        u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h20);
        rchk(cci_pkg::ADDR_FLAGS, 8'h22);
        outs(3'h1, 1'b0);
        u_host.put(cci_pkg::ADDR_ERRFLAGS, 8'h00, 8'h80);
        rchk(cci_pkg::ADDR_ERRFLAGS, 8'h00);
        u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h22);
        outs(3'h0, 1'b1);
        // Error counter thresholds and state-change flag.
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            tec <= t_tec[i];
            rec <= t_rec[i];
            repeat (4) @(posedge sys_clk);
            #1;
            chk({2'h0, estate}, {2'h0, t_st[i]});
            rchk(cci_pkg::ADDR_ERRFLAGS, {2'h0, t_st[i]});
            rchk(cci_pkg::ADDR_FLAGS, (i == 0 || i == 2) ? 8'h00 : 8'h20);
            u_host.put(cci_pkg::ADDR_FLAGS, 8'h00, 8'h20);
        end
        // Reset in mid-run returns everything to idle.
        u_host.put(cci_pkg::ADDR_FLAGS, 8'h02, 8'hFF);
        outs(3'h7, 1'b0);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        outs(3'h0, 1'b1);
        rchk(cci_pkg::ADDR_ENABLES, 8'h00);
        rchk(cci_pkg::ADDR_FLAGS, 8'h00);
        end_of_test();
    end
endmodule : cci_interrupt_unit_tb
